//--- logic/vsm_pkg.sv
// Constants, register map and state types for the supply supervisor controller
// ============================================================================
package vsm_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] LOW_CTL_ADDR = 8'h00;
    localparam logic [7:0] HIGH_CTL_ADDR = 8'h04;
    localparam logic [7:0] FLAGS_ADDR = 8'h08;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h0c;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
    localparam logic [7:0] STATE_ADDR = 8'h14;

    // ========================================================================
    // Control register fields, same layout on both sides
    localparam int CTL_SUP_EN = 0;
    localparam int CTL_SUP_MD = 1;
    localparam int CTL_SUP_FP = 2;
    localparam int CTL_MON_EN = 3;
    localparam int CTL_MON_FP = 4;
    localparam int CTL_ACE = 5;
    localparam int CTL_W = 6;
    localparam logic [5:0] LOW_CTL_RESET = 6'h09;
    localparam logic [5:0] HIGH_CTL_RESET = 6'h09;

    // Flag and interrupt bit positions
    localparam int FLG_LOW_DLY = 0;
    localparam int FLG_HIGH_DLY = 1;
    localparam int IRQ_LOW_DONE = 0;
    localparam int IRQ_HIGH_DONE = 1;
    localparam int IRQ_CORE_RST = 2;
    localparam int IRQ_STUCK = 3;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ========================================================================
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int SETTLE_FAST_US = 2;
    localparam int SETTLE_SLOW_US = 150;
    localparam int HAZARD_WIN_US = 1;
    localparam int SETTLE_FAST_CYC = SETTLE_FAST_US * CLK_MHZ;
    localparam int SETTLE_SLOW_CYC = SETTLE_SLOW_US * CLK_MHZ;
    localparam int HAZARD_WIN_CYC = HAZARD_WIN_US * CLK_MHZ;
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {SUP_OFF, SUP_NORMAL, SUP_FULL} vsm_sup_e;

    typedef struct packed {
        logic ace;
        logic mon_fp;
        logic mon_en;
        logic sup_fp;
        logic sup_md;
        logic sup_en;
    } vsm_ctl_s;

    typedef struct packed {
        vsm_sup_e low_sup;
        vsm_sup_e low_mon;
        vsm_sup_e high_sup;
        vsm_sup_e high_mon;
    } vsm_states_s;

endpackage

//--- logic/vsm_ctrl.sv
// Supply supervisor mode decode, settling delays, core reset and low-power wake control
`timescale 1ns/100ps
module vsm_ctrl #(
    parameter int SETTLE_SLOW_CYC = vsm_pkg::SETTLE_SLOW_CYC
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [vsm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [vsm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [vsm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic lpm_deep_req,
    input wire logic wake_event,
    input wire logic core_raise,
    input wire logic core_ok_pin,
    input wire logic power_up_clear,
    output vsm_pkg::vsm_states_s sup_states,
    output logic deep_mode,
    output logic wake_slow,
    output logic cpu_run,
    output logic lpm_stuck,
    output logic device_reset,
    output logic irq
);

    typedef enum logic [1:0] {PWR_ACTIVE, PWR_DEEP, PWR_WAKE, PWR_STUCK} vsm_pwr_e;

    // ========================================================================
    // Decode helpers
    function automatic vsm_pkg::vsm_sup_e sup_decode(
        input logic en,
        input logic md,
        input logic fp,
        input logic ace,
        input logic deep
    );
        vsm_pkg::vsm_sup_e act;
        act = fp ? vsm_pkg::SUP_FULL : vsm_pkg::SUP_NORMAL;
        if (!en)
            sup_decode = vsm_pkg::SUP_OFF;
        else if (!deep)
            sup_decode = act;
        else if (!md)
            sup_decode = vsm_pkg::SUP_OFF;
        else if (!ace)
            sup_decode = act;
        else if (fp)
            sup_decode = vsm_pkg::SUP_NORMAL;
        else
            sup_decode = vsm_pkg::SUP_OFF;
    endfunction

    function automatic vsm_pkg::vsm_sup_e mon_decode(
        input logic en,
        input logic fp,
        input logic ace,
        input logic deep
    );
        vsm_pkg::vsm_sup_e act;
        act = fp ? vsm_pkg::SUP_FULL : vsm_pkg::SUP_NORMAL;
        if (!en)
            mon_decode = vsm_pkg::SUP_OFF;
        else if (!deep || !ace)
            mon_decode = act;
        else if (fp)
            mon_decode = vsm_pkg::SUP_NORMAL;
        else
            mon_decode = vsm_pkg::SUP_OFF;
    endfunction

    localparam logic [vsm_pkg::CNT_W-1:0] FAST_CNT = vsm_pkg::CNT_W'(vsm_pkg::SETTLE_FAST_CYC);
    localparam logic [vsm_pkg::CNT_W-1:0] SLOW_CNT = vsm_pkg::CNT_W'(SETTLE_SLOW_CYC);
    localparam logic [vsm_pkg::CNT_W-1:0] WIN_CNT = vsm_pkg::CNT_W'(vsm_pkg::HAZARD_WIN_CYC);

    // ========================================================================
    // Registers
    vsm_pkg::vsm_ctl_s low_side_supervisor_control_q;
    vsm_pkg::vsm_ctl_s high_side_supervisor_control_q;
    logic [vsm_pkg::IRQ_W-1:0] irq_stat_q;
    logic [vsm_pkg::IRQ_W-1:0] irq_stat_d;
    logic [vsm_pkg::IRQ_W-1:0] irq_mask_q;
    logic [vsm_pkg::CNT_W-1:0] low_cnt_q;
    logic [vsm_pkg::CNT_W-1:0] high_cnt_q;
    logic [vsm_pkg::CNT_W-1:0] pwr_cnt_q;
    logic [vsm_pkg::CNT_W-1:0] win_cnt_q;
    logic low_side_delay_flag_q;
    logic high_side_delay_flag_q;
    logic raise_pend_q;
    logic core_s1_q;
    logic core_s2_q;
    logic core_s3_q;
    logic core_ok_q;
    logic armed_q;
    vsm_pwr_e pwr_q;
    vsm_pwr_e pwr_d;

    // ========================================================================
    // Address decode
    wire wr_low = reg_wr && (reg_addr == vsm_pkg::LOW_CTL_ADDR);
    wire wr_high = reg_wr && (reg_addr == vsm_pkg::HIGH_CTL_ADDR);
    wire wr_mask = reg_wr && (reg_addr == vsm_pkg::IRQ_MASK_ADDR);
    wire rd_stat = reg_rd && (reg_addr == vsm_pkg::IRQ_STAT_ADDR);
    wire deep = (pwr_q != PWR_ACTIVE);

    vsm_pkg::vsm_ctl_s lc;
    vsm_pkg::vsm_ctl_s hc;
    assign lc = low_side_supervisor_control_q;
    assign hc = high_side_supervisor_control_q;

    // ========================================================================
    // Mode decode
    vsm_pkg::vsm_states_s st_d;
    assign st_d.low_sup = sup_decode(lc.sup_en, lc.sup_md, lc.sup_fp, lc.ace, deep);
    assign st_d.low_mon = mon_decode(lc.mon_en, lc.mon_fp, lc.ace, deep);
    assign st_d.high_sup = sup_decode(hc.sup_en, hc.sup_md, hc.sup_fp, hc.ace, deep);
    assign st_d.high_mon = mon_decode(hc.mon_en, hc.mon_fp, hc.ace, deep);

    // Slow wake-up when either low-side unit sits in normal performance
    wire slow_wake_d = (lc.sup_en && !lc.sup_fp) || (lc.mon_en && !lc.mon_fp);

    // Active and deep states, compared directly so the test does not depend on pwr_q
    wire hs_act_norm = hc.sup_en && !hc.sup_fp;
    wire hs_deep_off = sup_decode(hc.sup_en, hc.sup_md, hc.sup_fp, hc.ace, 1'b1)
                       == vsm_pkg::SUP_OFF;
    wire hm_act_norm = hc.mon_en && !hc.mon_fp;
    wire hm_deep_off = mon_decode(hc.mon_en, hc.mon_fp, hc.ace, 1'b1) == vsm_pkg::SUP_OFF;
    wire high_drop = (hs_act_norm && hs_deep_off) || (hm_act_norm && hm_deep_off);
    // Manual and always-on high side keeps high_drop low, avoiding the hazard
    wire low_fast = !slow_wake_d;
    wire cfg_hazard = low_fast && high_drop;
    wire dly_pending = low_side_delay_flag_q || high_side_delay_flag_q;

    // ========================================================================
    // Settling delays
    wire low_expire = low_side_delay_flag_q && (low_cnt_q == '0);
    wire high_expire = high_side_delay_flag_q && (high_cnt_q == '0);
    wire low_start = wr_low || core_raise;
    // Length follows the value being written so the new mode governs its own settling
    wire low_fp_new = wr_low ? reg_wdata[vsm_pkg::CTL_SUP_FP] : lc.sup_fp;
    wire [vsm_pkg::CNT_W-1:0] low_load = low_fp_new ? FAST_CNT - 1'b1 : SLOW_CNT - 1'b1;
    wire [vsm_pkg::CNT_W-1:0] high_load = reg_wdata[vsm_pkg::CTL_SUP_FP]
                                          ? FAST_CNT - 1'b1 : SLOW_CNT - 1'b1;
    // A raise still pending when settling ends with core low trips the reset
    wire core_fail = low_expire && raise_pend_q && !core_ok_q;

    // ========================================================================
    // Power state machine
    wire hang = cfg_hazard || armed_q;
    always_comb
    begin
        pwr_d = pwr_q;
        case (pwr_q)
            PWR_ACTIVE:
                if (lpm_deep_req)
                    pwr_d = PWR_DEEP;
            PWR_DEEP:
                if (wake_event)
                    pwr_d = (win_cnt_q != '0 && hang) ? PWR_STUCK : PWR_WAKE;
            PWR_WAKE:
                if (pwr_cnt_q == '0)
                    pwr_d = PWR_ACTIVE;
            PWR_STUCK:
                if (power_up_clear)
                    pwr_d = PWR_ACTIVE;
            default:
                pwr_d = PWR_ACTIVE;
        endcase
    end

    // ========================================================================
    // Interrupt status, set wins over read clear
    wire [vsm_pkg::IRQ_W-1:0] irq_set = {pwr_d == PWR_STUCK && pwr_q != PWR_STUCK,
                                         core_fail, high_expire, low_expire};
    assign irq_stat_d = (rd_stat ? '0 : irq_stat_q) | irq_set;

    // ========================================================================
    // Read mux
    logic [vsm_pkg::DATA_W-1:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        if (reg_addr == vsm_pkg::LOW_CTL_ADDR)
            rd_mux = vsm_pkg::DATA_W'(lc);
        else if (reg_addr == vsm_pkg::HIGH_CTL_ADDR)
            rd_mux = vsm_pkg::DATA_W'(hc);
        else if (reg_addr == vsm_pkg::FLAGS_ADDR)
            rd_mux = vsm_pkg::DATA_W'({high_side_delay_flag_q, low_side_delay_flag_q});
        else if (reg_addr == vsm_pkg::IRQ_STAT_ADDR)
            rd_mux = vsm_pkg::DATA_W'(irq_stat_q);
        else if (reg_addr == vsm_pkg::IRQ_MASK_ADDR)
            rd_mux = vsm_pkg::DATA_W'(irq_mask_q);
        else if (reg_addr == vsm_pkg::STATE_ADDR)
            rd_mux = vsm_pkg::DATA_W'({pwr_q, sup_states});
    end

    // ========================================================================
    // Core level pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_s1_q <= 1'b0;
            core_s2_q <= 1'b0;
            core_s3_q <= 1'b0;
            core_ok_q <= 1'b0;
        end
        else
        begin
            core_s1_q <= core_ok_pin;
            core_s2_q <= core_s1_q;
            core_s3_q <= core_s2_q;
            if (core_s2_q == core_s3_q)
                core_ok_q <= core_s3_q;
        end
    end

    // ========================================================================
    // Control registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_side_supervisor_control_q <= vsm_pkg::LOW_CTL_RESET;
            high_side_supervisor_control_q <= vsm_pkg::HIGH_CTL_RESET;
            irq_mask_q <= vsm_pkg::IRQ_MASK_RESET;
            irq_stat_q <= '0;
            reg_rdata <= '0;
        end
        else
        begin
            if (wr_low)
                low_side_supervisor_control_q <= reg_wdata[vsm_pkg::CTL_W-1:0];
            if (wr_high)
                high_side_supervisor_control_q <= reg_wdata[vsm_pkg::CTL_W-1:0];
            if (wr_mask)
                irq_mask_q <= reg_wdata[vsm_pkg::IRQ_W-1:0];
            irq_stat_q <= irq_stat_d;
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // ========================================================================
    // Low side settling
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_side_delay_flag_q <= 1'b0;
            low_cnt_q <= '0;
            raise_pend_q <= 1'b0;
        end
        else
        begin
            if (low_start)
            begin
                low_side_delay_flag_q <= 1'b1;
                low_cnt_q <= low_load;
            end
            else if (low_expire)
                low_side_delay_flag_q <= 1'b0;
            else if (low_side_delay_flag_q)
                low_cnt_q <= low_cnt_q - 1'b1;
            if (core_raise)
                raise_pend_q <= 1'b1;
            else if (low_expire)
                raise_pend_q <= 1'b0;
        end
    end

    // ========================================================================
    // High side settling
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_side_delay_flag_q <= 1'b0;
            high_cnt_q <= '0;
        end
        else
        begin
            if (wr_high)
            begin
                high_side_delay_flag_q <= 1'b1;
                high_cnt_q <= high_load;
            end
            else if (high_expire)
                high_side_delay_flag_q <= 1'b0;
            else if (high_side_delay_flag_q)
                high_cnt_q <= high_cnt_q - 1'b1;
        end
    end

    // ========================================================================
    // Power state, entry window and wake timer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_q <= PWR_ACTIVE;
            win_cnt_q <= '0;
            pwr_cnt_q <= '0;
            armed_q <= 1'b0;
        end
        else
        begin
            pwr_q <= pwr_d;
            if (pwr_q == PWR_ACTIVE && pwr_d == PWR_DEEP)
            begin
                win_cnt_q <= WIN_CNT;
                // Entry with settling still running leaves the wake path unsafe
                armed_q <= dly_pending;
            end
            else if (win_cnt_q != '0)
                win_cnt_q <= win_cnt_q - 1'b1;
            if (pwr_q == PWR_DEEP && pwr_d == PWR_WAKE)
                pwr_cnt_q <= slow_wake_d ? SLOW_CNT - 1'b1 : FAST_CNT - 1'b1;
            else if (pwr_cnt_q != '0)
                pwr_cnt_q <= pwr_cnt_q - 1'b1;
        end
    end

    // ========================================================================
    // Registered outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sup_states <= '0;
            deep_mode <= 1'b0;
            wake_slow <= 1'b0;
            cpu_run <= 1'b1;
            lpm_stuck <= 1'b0;
            device_reset <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            sup_states <= st_d;
            deep_mode <= (pwr_d != PWR_ACTIVE);
            wake_slow <= slow_wake_d;
            cpu_run <= (pwr_d == PWR_ACTIVE);
            lpm_stuck <= (pwr_d == PWR_STUCK);
            device_reset <= core_fail;
            irq <= |(irq_stat_d & irq_mask_q);
        end
    end

endmodule

//--- sim/vsm_ctrl_assertions.sv
// Port-level assertions for the supply supervisor controller
`timescale 1ns/100ps
module vsm_ctrl_assertions #(
    parameter int SETTLE_SLOW_CYC = 200
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [vsm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [vsm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [vsm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic lpm_deep_req,
    input wire logic wake_event,
    input wire logic core_raise,
    input wire logic core_ok_pin,
    input wire logic power_up_clear,
    input wire vsm_pkg::vsm_states_s sup_states,
    input wire logic deep_mode,
    input wire logic wake_slow,
    input wire logic cpu_run,
    input wire logic lpm_stuck,
    input wire logic device_reset,
    input wire logic irq
);
    // ========================================================================
    // Helpers
    wire logic unmapped = !(reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14});
    wire logic low_norm = (sup_states.low_sup == vsm_pkg::SUP_NORMAL) ||
        (sup_states.low_mon == vsm_pkg::SUP_NORMAL);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ========================================================================
    // Properties
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    property p_unmapped;
        reg_rd && unmapped |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_reset_pulse;
        device_reset |=> !device_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("device reset too long");

    property p_stuck_deep;
        lpm_stuck |-> deep_mode && !cpu_run;
    endproperty
    a_stuck_deep: assert property (p_stuck_deep) else $error("stuck while running");

    property p_run_deep;
        cpu_run != deep_mode;
    endproperty
    a_run_deep: assert property (p_run_deep) else $error("run and deep disagree");

    property p_deep_entry;
        lpm_deep_req && cpu_run |=> deep_mode;
    endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("deep entry missed");

    property p_clear;
        lpm_stuck && power_up_clear |-> ##[1:2] !lpm_stuck;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not free stuck");

    // A wake that is not a hang recovery passes the wake timer, so deep stood for a while
    property p_deep_hold;
        $fell(deep_mode) && !$past(lpm_stuck) |-> $past(deep_mode, 8);
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("deep left too soon");

    property p_wake_slow;
        !deep_mode && !$past(deep_mode) && $stable(wake_slow) && $stable(sup_states)
            |-> wake_slow == low_norm;
    endproperty
    a_wake_slow: assert property (p_wake_slow) else $error("wake speed wrong");

    c_reset: cover property (device_reset);
    c_stuck: cover property ($rose(lpm_stuck));
    c_wake: cover property ($fell(deep_mode));
endmodule

bind vsm_ctrl vsm_ctrl_assertions #(.SETTLE_SLOW_CYC(SETTLE_SLOW_CYC)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lpm_deep_req(lpm_deep_req),
    .wake_event(wake_event), .core_raise(core_raise), .core_ok_pin(core_ok_pin),
    .power_up_clear(power_up_clear), .sup_states(sup_states), .deep_mode(deep_mode),
    .wake_slow(wake_slow), .cpu_run(cpu_run), .lpm_stuck(lpm_stuck),
    .device_reset(device_reset), .irq(irq));

//--- sim/vsm_ctrl_tb_top.sv
// Self-checking bench for the supply supervisor controller
`timescale 1ns/100ps
module vsm_ctrl_tb_top;
    // Short slow count keeps the run small; it must stay above the fast count
    localparam int SLOW = 200;
    localparam int FAST = vsm_pkg::SETTLE_FAST_CYC;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic lpm_deep_req = 1'b0;
    logic wake_event = 1'b0;
    logic core_raise = 1'b0;
    logic core_ok_pin = 1'b1;
    logic power_up_clear = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, rd_v;
    logic deep_mode, wake_slow, cpu_run, lpm_stuck, device_reset, irq, seen, ws, haz;
    vsm_pkg::vsm_states_s sup_states;
    logic [5:0] lo, hi;
    logic [7:0] st_a, st_d;
    int num_errors = 0;
    int tests_run = 0;
    int cnt, n;

    vsm_ctrl #(.SETTLE_SLOW_CYC(SLOW)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .lpm_deep_req(lpm_deep_req), .wake_event(wake_event),
        .core_raise(core_raise), .core_ok_pin(core_ok_pin), .power_up_clear(power_up_clear),
        .sup_states(sup_states), .deep_mode(deep_mode), .wake_slow(wake_slow),
        .cpu_run(cpu_run), .lpm_stuck(lpm_stuck), .device_reset(device_reset), .irq(irq));

    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end

    // ========================================================================
    // Reference model of the state decode
    function automatic logic [1:0] sup_m(input logic [5:0] c, input logic d);
        if (!c[0]) return 2'h0;
        if (!d) return c[2] ? 2'h2 : 2'h1;
        if (c[5]) return (c[1] && c[2]) ? 2'h1 : 2'h0;
        return c[1] ? (c[2] ? 2'h2 : 2'h1) : 2'h0;
    endfunction

    function automatic logic [1:0] mon_m(input logic [5:0] c, input logic d);
        if (!c[3]) return 2'h0;
        if (d && c[5]) return c[4] ? 2'h1 : 2'h0;
        return c[4] ? 2'h2 : 2'h1;
    endfunction

    // ========================================================================
    // Bus and check tasks
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask

    // 0 deep request, 1 wake, 2 core raise, 3 power-up clear
    task automatic pulse(input int k);
        @(posedge ref_clk);
        case (k)
            0: lpm_deep_req <= 1'b1;
            1: wake_event <= 1'b1;
            2: core_raise <= 1'b1;
            default: power_up_clear <= 1'b1;
        endcase
        @(posedge ref_clk);
        {lpm_deep_req, wake_event, core_raise, power_up_clear} <= 4'h0;
    endtask

    task automatic wait_flags();
        cnt = 0;
        do
        begin
            rd(8'h08, rd_v);
            cnt += 2;
        end
        while (rd_v[1:0] !== 2'b00 && cnt < 1000);
        if (cnt >= 1000)
        begin
            num_errors++;
            test_done();
        end
    endtask

    task automatic wait_run();
        cnt = 0;
        while (cpu_run !== 1'b1 && cnt < 1000)
        begin
            tick(1);
            cnt++;
        end
        if (cnt >= 1000)
        begin
            num_errors++;
            test_done();
        end
    endtask

    // ========================================================================
    // Scenarios
    initial
    begin
        void'($urandom(32'h27d693af));
        tick(6);
        rst_n <= 1'b1;
        tick(2);
        for (int k = 0; k < 7; k++)
        begin
            rd(8'(4 * k), rd_v);
            check("reset read", k < 2 ? 16'h0009 : (k == 5 ? 16'h0055 : 16'h0000), rd_v);
        end
        $display("test reset done");
        for (int i = 0; i < 64; i++)
        begin
            lo = 6'(i);
            hi = 6'($urandom);
            st_a = {sup_m(lo, 1'b0), mon_m(lo, 1'b0), sup_m(hi, 1'b0), mon_m(hi, 1'b0)};
            st_d = {sup_m(lo, 1'b1), mon_m(lo, 1'b1), sup_m(hi, 1'b1), mon_m(hi, 1'b1)};
            ws = (lo[0] & ~lo[2]) | (lo[3] & ~lo[4]);
            haz = ~ws & ((st_a[3:2] == 2'h1 && st_d[3:2] == 2'h0) ||
                (st_a[1:0] == 2'h1 && st_d[1:0] == 2'h0));
            wr(8'h00, {10'h000, lo});
            wr(8'h04, {10'h000, hi});
            wait_flags();
            rd(8'h00, rd_v);
            check("low ctl", {10'h000, lo}, rd_v);
            check("active states", 16'(st_a), 16'(sup_states));
            check("wake slow", 16'(ws), 16'(wake_slow));
            pulse(0);
            tick(3);
            check("deep states", 16'(st_d), 16'(sup_states));
            pulse(1);
            tick(3);
            check("stuck", 16'(haz), 16'(lpm_stuck));
            if (lpm_stuck === 1'b1)
                pulse(3);
            wait_run();
            n = ws ? SLOW : FAST;
            if (!haz)
                check("wake time", 16'h0001, 16'(cnt >= n - 6 && cnt <= n + 4));
        end
        $display("test decode done");
        check("masked irq", 16'h0000, 16'(irq));
        wr(8'h10, 16'h0001);
        rd(8'h0c, rd_v);
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h00, k ? 16'h0009 : 16'h000d);
            wait_flags();
            n = k ? SLOW : FAST;
            check("settle time", 16'h0001, 16'(cnt >= n - 4 && cnt <= n + 6));
            tick(2);
            check("irq set", 16'h0001, 16'(irq));
            rd(8'h0c, rd_v);
            check("status", 16'h0001, 16'(rd_v[0]));
            tick(2);
            check("irq clear", 16'h0000, 16'(irq));
        end
        $display("test settle done");
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h00, k ? 16'h0009 : 16'h000d);
            wait_flags();
            core_ok_pin <= 1'b0;
            pulse(2);
            seen = 1'b0;
            for (int c = 0; c < 260; c++)
            begin
                tick(1);
                // Core ramp finishes after the fast delay but inside the slow one
                if (c == 150)
                    core_ok_pin <= 1'b1;
                seen |= device_reset;
            end
            check("core reset", 16'(k == 0), 16'(seen));
            rd(8'h0c, rd_v);
            check("core status", 16'(k == 0), 16'(rd_v[2]));
        end
        $display("test core done");
        // Low side fast, high side manual and on in deep sleep: wake must succeed
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'h000b);
        wait_flags();
        pulse(0);
        tick(1);
        check("deep mode", 16'h0001, 16'(deep_mode));
        pulse(1);
        tick(3);
        check("kept on", 16'h0000, 16'(lpm_stuck));
        wait_run();
        check("kept on wake", 16'h0001, 16'(cnt >= FAST - 6 && cnt <= FAST + 4));
        $display("test kept on done");
        wr(8'h00, 16'h0009);
        pulse(0);
        pulse(1);
        tick(3);
        check("stuck after write", 16'h0001, 16'(lpm_stuck));
        tick(300);
        check("still stuck", 16'h0001, 16'(lpm_stuck));
        rd(8'h0c, rd_v);
        check("stuck status", 16'h0001, 16'(rd_v[3]));
        rst_n <= 1'b0;
        tick(1);
        rst_n <= 1'b1;
        tick(2);
        check("reset recovery", 16'h0001, 16'({cpu_run, lpm_stuck} == 2'b10));
        $display("test stuck done");
        test_done();
    end

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        num_errors++;
        test_done();
    end
endmodule
